// >>> shared/swdt_pkg.sv
// package for the system watchdog: widths, prescaler ratios, reset values
// assumes one system clock and an active-low application reset
package swdt_pkg;
   // ****************************************
   // counter and prescaler
   // ****************************************
   localparam int CNT_W = 16;
   localparam int RELOAD_W = 8;
   localparam int PRE_W = 14;
   localparam logic [PRE_W-1:0] PRE_DIV_SLOW = 14'h3fff; // last count of 16384
   localparam logic [PRE_W-1:0] PRE_DIV_FAST = 14'h00ff; // last count of 256
   localparam logic [PRE_W-1:0] PRE_ZERO = 14'h0000;
   localparam logic [PRE_W-1:0] PRE_ONE = 14'h0001;
   localparam logic [CNT_W-1:0] CNT_ONES = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [RELOAD_W-1:0] RELOAD_RESET = 8'h00;
   // ****************************************
   // overflow sequence timing
   // ****************************************
   localparam int WARN_W = 8;
   localparam logic [WARN_W-1:0] WARN_CYCLES = 8'h10; // prewarning lead before reset
   localparam logic [WARN_W-1:0] WARN_ONE = 8'h01;
   localparam logic [WARN_W-1:0] WARN_ZERO = 8'h00;
   typedef enum logic [1:0] {SWDT_RUN, SWDT_WARN, SWDT_RESET} swdt_state_t;
endpackage : swdt_pkg

// >>> hdl/swdt_prescaler.sv
// prescaler for the system watchdog: one-cycle tick per selected period
// assumes clear and select are synchronous to clock
`timescale 1ns/10ps
module swdt_prescaler (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // control
   input wire logic run,
   input wire logic clear,
   input wire logic fast_sel,
   // tick out
   output logic tick
);
   logic [swdt_pkg::PRE_W-1:0] cnt_r;
   logic [swdt_pkg::PRE_W-1:0] cnt_nxt;
   wire [swdt_pkg::PRE_W-1:0] last_count;
   wire at_last;

   assign last_count = fast_sel ? swdt_pkg::PRE_DIV_FAST : swdt_pkg::PRE_DIV_SLOW;
   // a narrowed ratio mid-period must still end the period
   assign at_last = (cnt_r >= last_count);
   assign tick = run && !clear && at_last;

   always_comb begin
      if (clear || !run || at_last) begin
         cnt_nxt = swdt_pkg::PRE_ZERO;
      end else begin
         cnt_nxt = cnt_r + swdt_pkg::PRE_ONE;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= swdt_pkg::PRE_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   a_tick_period: assert property (@(posedge clock) disable iff (!resetn)
      tick |-> (cnt_r == last_count) || (cnt_r > last_count))
      else $error("prescaler tick off its period");
   a_clear_zero: assert property (@(posedge clock) disable iff (!resetn)
      clear |=> (cnt_r == swdt_pkg::PRE_ZERO))
      else $error("prescaler not cleared by service");
endmodule : swdt_prescaler

// >>> hdl/swdt_top.sv
// system watchdog: 16-bit up counter with prescaler, reload, prewarning and reset request
// assumes cpu strobes are one-cycle pulses synchronous to clock
//
// Operation
// - after every application reset the watchdog counts without software action
// - disable instruction stops it, enable instruction restarts it, until an overflow starts the prewarning and reset sequence
// - on overflow raise prewarning interrupt first, then a reset request
// - the watchdog counter is sixteen bits wide
// - counter advances once per prescaler period of 16384 or 256 clocks
// - counter loads from the software reload value
// - service reloads the counter and clears the prescaler together
`timescale 1ns/10ps
module swdt_top #(
   parameter logic [swdt_pkg::WARN_W-1:0] WARN_LEAD = swdt_pkg::WARN_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // cpu instruction strobes
   input wire logic watchdog_disable_instruction,
   input wire logic watchdog_enable_instruction,
   input wire logic service,
   // configuration
   input wire logic [swdt_pkg::RELOAD_W-1:0] reload_value_field,
   input wire logic fast_sel,
   // status and requests
   output logic enabled,
   output logic [swdt_pkg::CNT_W-1:0] count,
   output logic prewarn_irq,
   output logic reset_req
);
   // ****************************************
   // state
   // ****************************************
   logic enabled_r;
   logic [swdt_pkg::CNT_W-1:0] cnt_r;
   logic [swdt_pkg::CNT_W-1:0] cnt_nxt;
   logic [swdt_pkg::WARN_W-1:0] warn_r;
   logic [swdt_pkg::WARN_W-1:0] warn_nxt;
   swdt_pkg::swdt_state_t state_r;
   swdt_pkg::swdt_state_t state_nxt;
   logic prewarn_r;
   logic reset_req_r;
   wire tick;
   wire overflow;
   wire [swdt_pkg::CNT_W-1:0] reload_word;
   wire running;
   wire svc_ok;

   // ****************************************
   // decode
   // ****************************************
   // once the overflow sequence starts, service can no longer avert it
   assign svc_ok = service && (state_r == swdt_pkg::SWDT_RUN);
   assign running = enabled_r && (state_r == swdt_pkg::SWDT_RUN);
   assign reload_word = {reload_value_field, {swdt_pkg::RELOAD_W{1'b0}}};
   assign overflow = tick && (cnt_r == swdt_pkg::CNT_ONES);

   swdt_prescaler u_pre (
      .clock(clock),
      .resetn(resetn),
      .run(running),
      .clear(svc_ok),
      .fast_sel(fast_sel),
      .tick(tick)
   );

   // ****************************************
   // enable and counter
   // ****************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         enabled_r <= 1'b1;
      end else if (watchdog_disable_instruction) begin
         enabled_r <= 1'b0;
      end else if (watchdog_enable_instruction) begin
         enabled_r <= 1'b1;
      end
   end

   always_comb begin
      if (svc_ok) begin
         cnt_nxt = reload_word;
      end else if (tick) begin
         cnt_nxt = cnt_r + swdt_pkg::CNT_ONE;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= swdt_pkg::CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************
   // overflow sequence
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      warn_nxt = warn_r;
      case (state_r)
         swdt_pkg::SWDT_RUN: begin
            if (overflow) begin
               state_nxt = swdt_pkg::SWDT_WARN;
               warn_nxt = WARN_LEAD;
            end
         end
         swdt_pkg::SWDT_WARN: begin
            if (warn_r <= swdt_pkg::WARN_ONE) begin
               state_nxt = swdt_pkg::SWDT_RESET;
               warn_nxt = swdt_pkg::WARN_ZERO;
            end else begin
               warn_nxt = warn_r - swdt_pkg::WARN_ONE;
            end
         end
         default: begin
            state_nxt = swdt_pkg::SWDT_RESET;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= swdt_pkg::SWDT_RUN;
         warn_r <= swdt_pkg::WARN_ZERO;
         prewarn_r <= 1'b0;
         reset_req_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         warn_r <= warn_nxt;
         prewarn_r <= (state_nxt != swdt_pkg::SWDT_RUN);
         reset_req_r <= (state_nxt == swdt_pkg::SWDT_RESET);
      end
   end

   assign enabled = enabled_r;
   assign count = cnt_r;
   assign prewarn_irq = prewarn_r;
   assign reset_req = reset_req_r;

   // ****************************************
   // checks
   // ****************************************
   sequence s_overflow;
      overflow && (state_r == swdt_pkg::SWDT_RUN);
   endsequence
   sequence s_warn_then_reset;
      prewarn_irq && !reset_req ##[1:255] reset_req;
   endsequence

   a_warn_before_reset: assert property (@(posedge clock) disable iff (!resetn)
      s_overflow |=> s_warn_then_reset)
      else $error("prewarning did not precede reset request");
   a_reset_needs_warn: assert property (@(posedge clock) disable iff (!resetn)
      $rose(reset_req) |-> $past(prewarn_irq))
      else $error("reset request without prewarning");
   a_enabled_reset: assert property (@(posedge clock)
      $rose(resetn) |-> enabled)
      else $error("watchdog not enabled after reset");
   a_disable_stops: assert property (@(posedge clock) disable iff (!resetn)
      watchdog_disable_instruction |=> !enabled ##1 ($stable(count) || $past(service)))
      else $error("disable did not stop the counter");
   a_enable_starts: assert property (@(posedge clock) disable iff (!resetn)
      watchdog_enable_instruction && !watchdog_disable_instruction |=> enabled)
      else $error("enable did not restart the watchdog");
   a_service_reload: assert property (@(posedge clock) disable iff (!resetn)
      svc_ok |=> count == {$past(reload_value_field), 8'h00})
      else $error("service did not reload the counter");
   a_count_step: assert property (@(posedge clock) disable iff (!resetn)
      tick && !svc_ok |=> count == $past(count) + 16'h0001)
      else $error("counter did not advance on tick");
   a_idle_hold: assert property (@(posedge clock) disable iff (!resetn)
      !tick && !svc_ok |=> $stable(count))
      else $error("counter moved without a tick");
   a_overflow_wrap: assert property (@(posedge clock) disable iff (!resetn)
      s_overflow |=> prewarn_irq)
      else $error("overflow past all ones not flagged");
endmodule : swdt_top

// >>> testbench/swdt_top_test.sv
// bench for the system watchdog: directed scenarios on strobes and the fast/slow prescaler
// assumes the top with a short prewarning lead of two cycles
`timescale 1ns/10ps
module swdt_top_test;
   logic clock, resetn, dis, ena, service, fast_sel;
   logic [7:0] reload;
   logic enabled, prewarn_irq, reset_req;
   logic [15:0] count, held;
   int err_count, n_compared;
   swdt_top #(.WARN_LEAD(8'h02)) uut (.clock(clock), .resetn(resetn),
      .watchdog_disable_instruction(dis), .watchdog_enable_instruction(ena),
      .service(service), .reload_value_field(reload), .fast_sel(fast_sel),
      .enabled(enabled), .count(count), .prewarn_irq(prewarn_irq), .reset_req(reset_req));
   // ****************************************
   // helpers
   // ****************************************
   task stop_test;
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   // bounded wait until the counter shows v
   task wait_cnt(input logic [15:0] v, input int lim);
      int i;
      i = 0;
      while (count !== v && i < lim) begin
         cyc(1);
         i++;
      end
      check(count, v, "count wait");
      if (count !== v) stop_test();
   endtask : wait_cnt
   // ratio changes land on a clock edge, like every other strobe
   task set_fast(input logic f);
      @(posedge clock);
      fast_sel <= f;
      #1;
   endtask : set_fast
   task serve(input logic [7:0] r);
      @(posedge clock);
      reload <= r;
      service <= 1'b1;
      @(posedge clock);
      service <= 1'b0;
      #1;
   endtask : serve
   task do_reset;
      @(posedge clock);
      resetn <= 1'b0;
      cyc(8);
      check({13'h0, enabled, prewarn_irq, reset_req}, 16'h0004, "reset flags");
      check(count, 16'h0000, "reset count");
      @(posedge clock);
      resetn <= 1'b1;
      #1;
   endtask : do_reset
   // ****************************************
   // scenarios
   // ****************************************
   task t_fast;
      set_fast(1'b1);
      wait_cnt(16'h0001, 300);
      // let the prescaler get well into its period so a missed clear would tick early
      cyc(200);
      serve(8'hab);
      check(count, 16'hab00, "reload");
      cyc(250);
      check(count, 16'hab00, "prescaler cleared");
      wait_cnt(16'hab01, 10);
   endtask : t_fast
   task t_slow;
      set_fast(1'b0);
      serve(8'h00);
      cyc(16300);
      check(count, 16'h0000, "slow early");
      wait_cnt(16'h0001, 150);
   endtask : t_slow
   task t_onoff;
      set_fast(1'b1);
      @(posedge clock);
      dis <= 1'b1;
      ena <= 1'b1;
      @(posedge clock);
      ena <= 1'b0;
      @(posedge clock);
      dis <= 1'b0;
      #1;
      check({15'h0, enabled}, 16'h0000, "disable wins");
      held = count;
      cyc(600);
      check(count, held, "frozen");
      @(posedge clock);
      ena <= 1'b1;
      @(posedge clock);
      ena <= 1'b0;
      #1;
      check({15'h0, enabled}, 16'h0001, "enable");
      wait_cnt(held + 16'h0001, 300);
   endtask : t_onoff
   task t_overflow;
      set_fast(1'b1);
      serve(8'hff);
      wait_cnt(16'hffff, 65600);
      check({14'h0, prewarn_irq, reset_req}, 16'h0000, "no early warn");
      wait_cnt(16'h0000, 300);
      check({14'h0, prewarn_irq, reset_req}, 16'h0002, "prewarn first");
      cyc(1);
      check({15'h0, reset_req}, 16'h0000, "lead");
      cyc(1);
      check({14'h0, prewarn_irq, reset_req}, 16'h0003, "reset request");
      serve(8'h12);
      cyc(300);
      check(count, 16'h0000, "late service ignored");
      check({14'h0, prewarn_irq, reset_req}, 16'h0003, "requests stand");
   endtask : t_overflow
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      resetn = 1'b0;
      dis = 1'b0;
      ena = 1'b0;
      service = 1'b0;
      fast_sel = 1'b1;
      reload = 8'h00;
      err_count = 0;
      n_compared = 0;
      do_reset();
      t_fast();
      t_slow();
      t_onoff();
      t_overflow();
      do_reset();
      t_fast();
      stop_test();
   end
endmodule : swdt_top_test
